/* vcdac_ctrl.sv */
// Purpose: Serial target, DAC setting register and NV copy sequencer
// Assumes: scl is the link clock; nvm_rdata reflects the NV byte on mclk
// Notes: Open-drain sda as three signals; wp_n is an asynchronous pin
`include "vcdac_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module vcdac_ctrl import vcdac_pkg::*; #(
	parameter int unsigned PULSE_CYC = `VCDAC_PULSE_US * `VCDAC_CLK_MHZ,
	parameter int unsigned MAX_TRIES = `VCDAC_MAX_TRIES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic wp_n,
	output logic [7:0] dac_setting,
	output logic prog_busy,
	output logic prog_fail,
	output vcdac_nvm_s nvm_ctl,
	input wire logic [7:0] nvm_rdata
);

	localparam int unsigned CW = $clog2(PULSE_CYC + 1);
	localparam longint unsigned BUDGET =
		longint'(`VCDAC_PROG_MAX_MS) * 1000 * `VCDAC_CLK_MHZ;

	// Each attempt must fit so the worst case stays inside the budget
	if (PULSE_CYC < 2 || MAX_TRIES < 1 || MAX_TRIES > 7 ||
		longint'(2 * MAX_TRIES) * (PULSE_CYC + 2) > BUDGET) begin : g_bad
		$error("vcdac_ctrl: pulse length or tries out of range");
	end

	// ****************************************
	// Link domain (scl)
	// ****************************************
	logic frame_rst_q;
	logic lnk_rst_n;
	logic [3:0] bit_cnt_q;
	logic [6:0] shift_q;
	logic first_q;
	logic match_q;
	logic rw_q;
	logic [7:0] rd_q;
	logic oe_q;
	logic addr_tgl_q;
	logic data_tgl_q;
	logic [7:0] lnk_byte_q;
	logic [7:0] setting_q;
	logic [7:0] full_byte;
	logic nack_q;
	logic start_tgl_q;
	logic stop_tgl_q;

	// Frame reset is a flop, so it is glitch free as a reset source
	assign lnk_rst_n = rst_n & ~frame_rst_q;
	assign full_byte = {shift_q, sda_in};

	always_ff @(posedge scl or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			bit_cnt_q <= 4'h0;
			shift_q <= 7'h00;
			first_q <= 1'b1;
		end else if (bit_cnt_q == 4'h8) begin
			bit_cnt_q <= 4'h0;
			first_q <= 1'b0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q <= full_byte[6:0];
		end
	end

	always_ff @(posedge scl or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			match_q <= 1'b0;
			rw_q <= 1'b0;
		end else if (bit_cnt_q == 4'h7 && first_q) begin
			match_q <= full_byte[`VCDAC_ADDR_MSB:`VCDAC_ADDR_LSB] ==
				`VCDAC_TARGET_ADDR;
			rw_q <= full_byte[`VCDAC_RW_BIT];
		end
	end

	// Read byte is taken at the address ack; setting only moves on writes and the boot load
	always_ff @(posedge scl or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			rd_q <= `VCDAC_SETTING_RST;
			nack_q <= 1'b0;
		end else if (bit_cnt_q == 4'h8 && first_q) begin
			rd_q <= setting_q;
		end else if (bit_cnt_q == 4'h8 && sda_in) begin
			// Controller NACK ends the read, else sda blocks the STOP
			nack_q <= 1'b1;
		end
	end

	// Toggles survive frame resets, else a reset would fake an event
	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			addr_tgl_q <= 1'b0;
			data_tgl_q <= 1'b0;
			lnk_byte_q <= 8'h00;
		end else if (bit_cnt_q == 4'h7) begin
			if (first_q && full_byte[`VCDAC_ADDR_MSB:`VCDAC_ADDR_LSB] ==
				`VCDAC_TARGET_ADDR) begin
				addr_tgl_q <= ~addr_tgl_q;
				lnk_byte_q <= full_byte;
			end else if (!first_q && match_q && !rw_q) begin
				data_tgl_q <= ~data_tgl_q;
				lnk_byte_q <= full_byte;
			end
		end
	end

	// Ack regardless of wp_n; only the effects are gated
	always_ff @(negedge scl or negedge lnk_rst_n) begin
		if (!lnk_rst_n) begin
			oe_q <= 1'b0;
		end else if (bit_cnt_q == 4'h8) begin
			oe_q <= match_q & (first_q | ~rw_q);
		end else if (match_q && rw_q && !first_q && !nack_q) begin
			oe_q <= ~rd_q[3'h7 - bit_cnt_q[2:0]];
		end else begin
			oe_q <= 1'b0;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_q;

	// Start and stop seen on sda edges; scl is too fast to oversample
	always_ff @(negedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			start_tgl_q <= 1'b0;
		end else if (scl) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	always_ff @(posedge sda_in or negedge rst_n) begin
		if (!rst_n) begin
			stop_tgl_q <= 1'b0;
		end else if (scl) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	// ****************************************
	// Synchronisers into mclk
	// ****************************************
	logic [5:0] sy1_q;
	logic [5:0] sy2_q;
	logic [5:0] sy3_q;
	logic scl_s;
	logic wp_s;
	logic addr_evt;
	logic data_evt;
	logic start_det;
	logic stop_det;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q <= 6'h30;
			sy2_q <= 6'h30;
			sy3_q <= 6'h30;
		end else begin
			sy1_q <= {wp_n, scl, start_tgl_q, stop_tgl_q, addr_tgl_q,
				data_tgl_q};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	assign wp_s = sy2_q[5];
	assign scl_s = sy2_q[4];
	assign addr_evt = sy2_q[1] ^ sy3_q[1];
	assign data_evt = sy2_q[0] ^ sy3_q[0];
	assign start_det = sy2_q[3] ^ sy3_q[3];
	assign stop_det = sy2_q[2] ^ sy3_q[2];

	// ****************************************
	// Frame control
	// ****************************************
	vcdac_state_e state_q;
	logic start_seen_q;

	// Link logic held in reset while idle and until scl falls after start
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			frame_rst_q <= 1'b1;
			start_seen_q <= 1'b0;
		end else if (state_q == ST_LOAD || stop_det) begin
			frame_rst_q <= 1'b1;
			start_seen_q <= 1'b0;
		end else if (start_det) begin
			frame_rst_q <= 1'b1;
			start_seen_q <= 1'b1;
		end else if (start_seen_q && !scl_s) begin
			frame_rst_q <= 1'b0;
			start_seen_q <= 1'b0;
		end
	end

	// ****************************************
	// Setting register
	// ****************************************
	logic prog_sel_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			setting_q <= `VCDAC_SETTING_RST;
		end else if (state_q == ST_LOAD) begin
			setting_q <= nvm_rdata;
		end else if (data_evt && wp_s && prog_sel_q) begin
			setting_q <= lnk_byte_q;
		end
	end

	// Program bit of the last matched address byte
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prog_sel_q <= 1'b0;
		end else if (addr_evt) begin
			prog_sel_q <= lnk_byte_q[`VCDAC_PROG_BIT];
		end
	end

	assign dac_setting = setting_q;

	// ****************************************
	// NV copy sequencer
	// ****************************************
	logic [CW-1:0] cnt_q;
	logic [2:0] tries_q;
	logic [7:0] target_q;
	logic fail_q;
	logic prog_go;
	logic last_try;

	assign prog_go = addr_evt & wp_s & ~lnk_byte_q[`VCDAC_RW_BIT] &
		~lnk_byte_q[`VCDAC_PROG_BIT];
	assign last_try = tries_q == 3'(MAX_TRIES - 1);

	// wp_n is not looked at after the start, so it cannot abort
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_LOAD;
			cnt_q <= '0;
			tries_q <= 3'h0;
			target_q <= `VCDAC_SETTING_RST;
			fail_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_LOAD: begin
					state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					if (prog_go) begin
						state_q <= ST_ERASE;
						target_q <= setting_q;
						tries_q <= 3'h0;
						cnt_q <= '0;
						fail_q <= 1'b0;
					end
				end
				ST_ERASE, ST_WRITE: begin
					if (cnt_q == CW'(PULSE_CYC - 1)) begin
						cnt_q <= '0;
						state_q <= (state_q == ST_ERASE) ? ST_ECHK : ST_WCHK;
					end else begin
						cnt_q <= cnt_q + CW'(1);
					end
				end
				ST_ECHK: begin
					if (nvm_rdata == `VCDAC_ERASED_VAL) begin
						state_q <= ST_WRITE;
						tries_q <= 3'h0;
					end else if (last_try) begin
						state_q <= ST_IDLE;
						fail_q <= 1'b1;
					end else begin
						state_q <= ST_ERASE;
						tries_q <= tries_q + 3'h1;
					end
				end
				ST_WCHK: begin
					if (nvm_rdata == target_q) begin
						state_q <= ST_IDLE;
					end else if (last_try) begin
						state_q <= ST_IDLE;
						fail_q <= 1'b1;
					end else begin
						state_q <= ST_WRITE;
						tries_q <= tries_q + 3'h1;
					end
				end
			endcase
		end
	end

	assign nvm_ctl.erase = state_q[2];
	assign nvm_ctl.write = state_q[4];
	assign nvm_ctl.wdata = target_q;
	assign prog_busy = ~(state_q[0] | state_q[1]);
	assign prog_fail = fail_q;

endmodule : vcdac_ctrl

`default_nettype wire

/* vcdac_consts.svh */
// Purpose: Offsets, field positions and timing counts of the VCOM DAC target
// Assumes: Included by the control module and by its testbench
// Notes: Definitions only
`ifndef VCDAC_CONSTS_SVH
`define VCDAC_CONSTS_SVH

// ****************************************
// Address byte fields
// ****************************************
`define VCDAC_TARGET_ADDR 6'h27
`define VCDAC_ADDR_MSB 7
`define VCDAC_ADDR_LSB 2
`define VCDAC_PROG_BIT 1
`define VCDAC_RW_BIT 0

// ****************************************
// Reset values and NV cell
// ****************************************
`define VCDAC_SETTING_RST 8'h00
`define VCDAC_ERASED_VAL 8'hFF
`define VCDAC_MAX_TRIES 4

// ****************************************
// Timing
// ****************************************
`define VCDAC_CLK_MHZ 20
`define VCDAC_PULSE_US 10000
`define VCDAC_PROG_MAX_MS 100

`endif

/* vcdac_pkg.sv */
// Purpose: Types shared by the VCOM DAC target
// Assumes: Constants come from vcdac_consts.svh
// Notes: No logic here
package vcdac_pkg;

	// ****************************************
	// Programming sequencer states
	// ****************************************
	typedef enum logic [5:0] {
		ST_LOAD = 6'b00_0001,
		ST_IDLE = 6'b00_0010,
		ST_ERASE = 6'b00_0100,
		ST_ECHK = 6'b00_1000,
		ST_WRITE = 6'b01_0000,
		ST_WCHK = 6'b10_0000
	} vcdac_state_e;

	// ****************************************
	// Nonvolatile cell control
	// ****************************************
	typedef struct packed {
		logic erase;
		logic write;
		logic [7:0] wdata;
	} vcdac_nvm_s;

endpackage : vcdac_pkg

/* vcdac_ctrl_monitor.sv */
// Purpose: Port checks of the DAC setting and NV copy logic
// Assumes: Bound onto vcdac_ctrl, PULSE_CYC handed on
// Notes: All checks on mclk
`timescale 1ns/100ps
`default_nettype none
module vcdac_ctrl_monitor import vcdac_pkg::*; #(
	parameter int unsigned PULSE_CYC = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wp_n,
	input wire logic [7:0] dac_setting,
	input wire logic prog_busy,
	input wire logic prog_fail,
	input wire vcdac_nvm_s nvm_ctl,
	input wire logic [7:0] nvm_rdata
);
	// ****
	// Pulse length counter
	// ****
	logic [31:0] len_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) len_q <= '0;
		else if (nvm_ctl.erase | nvm_ctl.write) len_q <= len_q + 1;
		else len_q <= '0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	nv_excl_a: assert property (!(nvm_ctl.erase && nvm_ctl.write))
		else $error("erase and write together");
	boot_load_a: assert property ($rose(rst_n) |=>
		dac_setting == $past(nvm_rdata)) else $error("no boot load");
	// Eight cycles cover the pin sync and the update lag
	wp_set_a: assert property ((!wp_n && !prog_busy)[*8] |=>
		$stable(dac_setting)) else $error("write while protected");
	wp_prog_a: assert property ((!wp_n)[*8] |=> !$rose(prog_busy))
		else $error("program while protected");
	pulse_len_a: assert property ($fell(nvm_ctl.erase | nvm_ctl.write) |->
		len_q == PULSE_CYC) else $error("bad pulse length");
	prog_end_a: assert property ($rose(prog_busy) |-> ##[1:400] !prog_busy)
		else $error("programming too long");
	erase_busy_a: assert property (nvm_ctl.erase |-> prog_busy)
		else $error("erase outside programming");
	done_ok_a: assert property ($fell(prog_busy) &&
		($past(nvm_ctl.write, 2) || $past(nvm_ctl.erase, 2)) |->
		prog_fail || nvm_rdata == nvm_ctl.wdata) else $error("bad NV end");
	cover property ($fell(prog_busy));
	cover property ($rose(nvm_ctl.write));
	cover property ($changed(dac_setting) && wp_n);
endmodule : vcdac_ctrl_monitor
`default_nettype wire

/* vcdac_host.sv */
// Purpose: Serial bus controller model facing the target
// Assumes: sda pulled up; sda_oe high pulls it low
// Notes: scl stands high between frames, 12 ns bits
`timescale 1ns/100ps
`default_nettype none
module vcdac_host (
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// sda moves only mid-low so no false start or stop
	task automatic bit_io(input logic b, output logic s);
		#3 sda_oe = !b;
		#3 scl = 1'b1;
		s = sda;
		#6 scl = 1'b0;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] v, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
		bit_io(1'b1, ack);
		#96;
	endtask : byte_io
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r, output logic [1:0] ack);
		logic [7:0] u;
		sda_oe = 1'b1;
		#300 scl = 1'b0;
		// Target leaves frame reset only after it sees scl low
		#300;
		byte_io(a, u, ack[1]);
		byte_io(a[0] ? 8'hFF : d, r, ack[0]);
		#3 sda_oe = 1'b1;
		#3 scl = 1'b1;
		#300 sda_oe = 1'b0;
		#300;
	endtask : xfer
endmodule : vcdac_host
`default_nettype wire

/* vcdac_ctrl_tb.sv */
// Purpose: Self-checking bench of the DAC setting target
// Assumes: PULSE_CYC cut to 8 mclk cycles
// Notes: NV cell erases to FF, writes by AND
`include "vcdac_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module vcdac_ctrl_tb import vcdac_pkg::*; ;
	localparam logic [5:0] TA = `VCDAC_TARGET_ADDR;
	logic mclk = 0, rst_n = 0, wp_n = 1, scl, host_oe, sda_oe, sda_out;
	logic prog_busy, prog_fail;
	logic [7:0] dac_setting, nvm_rdata, r, v;
	logic [1:0] ack;
	vcdac_nvm_s nvm_ctl;
	int bad_count = 0, n_compared = 0;
	wire logic sda_in = !(host_oe | (sda_oe & !sda_out));
	vcdac_ctrl #(.PULSE_CYC(8)) u_dut (.mclk, .rst_n, .scl, .sda_in,
		.sda_out, .sda_oe, .wp_n, .dac_setting, .prog_busy, .prog_fail,
		.nvm_ctl, .nvm_rdata);
	vcdac_host u_host (.scl, .sda_oe(host_oe), .sda(sda_in));
	initial forever #25 mclk = ~mclk;
	always @(posedge mclk) begin
		if (nvm_ctl.erase) nvm_rdata <= 8'hFF;
		else if (nvm_ctl.write) nvm_rdata <= nvm_rdata & nvm_ctl.wdata;
	end
	// ****
	// Checks and ending
	// ****
	task automatic chk8(input string n, input logic [7:0] e,
		input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk8
	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		#200_000;
		bad_count++;
		wrap_up();
	end
	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(19443));
		nvm_rdata = 8'($urandom);
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk8("boot", nvm_rdata, dac_setting);
		$display("end boot");
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			u_host.xfer({TA, 2'b10}, v, r, ack);
			chk8("wr ack", 8'h00, {6'h00, ack});
			chk8("setting", v, dac_setting);
			u_host.xfer({TA, k[0], 1'b1}, 8'h00, r, ack);
			chk8("rd ack", 8'h01, {6'h00, ack});
			chk8("read", v, r);
		end
		$display("end write read");
		@(posedge mclk) wp_n <= 1'b0;
		repeat (4) @(posedge mclk);
		u_host.xfer({TA, 2'b10}, ~v, r, ack);
		chk8("wp ack", 8'h00, {6'h00, ack});
		chk8("wp set", v, dac_setting);
		u_host.xfer({TA, 2'b00}, 8'h00, r, ack);
		chk8("wp busy", 8'h00, {7'h00, prog_busy});
		u_host.xfer({TA, 2'b01}, 8'h00, r, ack);
		chk8("wp read", v, r);
		$display("end protect");
		@(posedge mclk) wp_n <= 1'b1;
		for (int b = 0; b < 6; b++) begin
			u_host.xfer({TA ^ (6'h01 << b), 2'b10}, ~v, r, ack);
			chk8("foreign ack", 8'h03, {6'h00, ack});
			chk8("foreign set", v, dac_setting);
		end
		$display("end address");
		v = ~nvm_rdata;
		u_host.xfer({TA, 2'b10}, v, r, ack);
		u_host.xfer({TA, 2'b00}, 8'h00, r, ack);
		@(posedge mclk) wp_n <= 1'b0;
		for (int t = 0; t < 400 && prog_busy; t++) @(posedge mclk);
		chk8("nv", v, nvm_rdata);
		chk8("fail", 8'h00, {7'h00, prog_fail});
		@(posedge mclk) rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk8("reload", v, dac_setting);
		$display("end program");
		wrap_up();
	end
endmodule : vcdac_ctrl_tb
bind vcdac_ctrl vcdac_ctrl_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.mclk,
	.rst_n, .wp_n, .dac_setting, .prog_busy, .prog_fail, .nvm_ctl,
	.nvm_rdata);
`default_nettype wire
